// ---- rtl/modbus_regmap_pkg.sv ----
// shared constants for the modbus register bank of the 16-input acquisition device
// assumes a 10 MHz clock and a request port fed by a modbus/tcp server front end
package modbus_regmap_pkg;
    localparam logic [15:0] CMD_ADDR   = 16'h07d6;
    localparam logic [15:0] STAT_ADDR  = 16'h1f3c;
    localparam logic [15:0] DIAG_ADDR  = 16'h1f3d;
    localparam logic [15:0] INPUT_ADDR = 16'h1f40;

    localparam logic [15:0] CMD_CLEAR_CODE = 16'h0080;
    localparam int          STAT_ERR_BIT   = 0;
    localparam int          DIAG_UNDER_BIT = 2;
    localparam int          DIAG_SURGE_BIT = 3;
    localparam int          DIAG_SHORT_BIT = 4;
    localparam int          DIAG_TEMP_BIT  = 10;
    localparam logic [15:0] DIAG_MASK      = 16'h041c;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    localparam logic [7:0] EXC_NONE          = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY          = 8'h06;

    localparam int CLK_HZ         = 10_000_000;
    localparam int CONN_READY_MS  = 350;
    localparam int EXCH_READY_MS  = 500;
    localparam int CONN_READY_CYC = CONN_READY_MS * (CLK_HZ / 1000);
    localparam int EXCH_READY_CYC = EXCH_READY_MS * (CLK_HZ / 1000);
    localparam int CNT_W          = 23;

    localparam int CONN_W = 3;
    localparam int SYNC_W = 20;

    typedef enum logic [2:0] {
        ST_BOOT   = 3'b001,
        ST_LISTEN = 3'b010,
        ST_RUN    = 3'b100
    } boot_state_e;
endpackage

// ---- rtl/pin_sync.sv ----
// two-flop synchroniser for a bundle of unrelated level inputs
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule

// ---- rtl/ready_timer.sv ----
// counts clock edges after reset release and raises done once limit is reached
// assumes limit is at least one and below two to the power of cnt_w
`timescale 1ns/1ns
module ready_timer
    import modbus_regmap_pkg::*;
#(
    parameter int LIMIT = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      done
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             done_r;
    logic             done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!done_r) begin
            cnt_nxt  = cnt_r + 1'b1;
            done_nxt = (cnt_r == CNT_W'(LIMIT - 1));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule

// ---- rtl/modbus_input_register_map.sv ----
// register bank behind the modbus/tcp server of a 16-input acquisition device
// assumes a server front end that presents one decoded register access per cycle
//
// What this block does
// - write to a read-only register is dropped and answered with exception 02
// - command write must have exactly one bit set, otherwise an error
// - command register is write-only; reads of it are refused
// - command bit 7 alone clears the latched i/o warning; others do nothing
// - status bit 0 is one while any diagnostic fault is present or the i/o warning is latched, else zero
// - diagnostic bit 2 follows sensor supply undervoltage
// - diagnostic bit 3 follows sensor supply surge
// - diagnostic bit 4 follows sensor supply short circuit or overload
// - diagnostic bit 10 follows device overtemperature
// - byte 0 holds inputs 1..8, byte 1 holds inputs 9..16, lowest at bit 0
// - the 16-bit input word maps byte-swapped onto one big-endian modbus register, byte 0 in the high byte; diagnostic bits are not swapped
// - byte-wide data sits in the low byte; high byte reads zero
// - connections are accepted within 350 ms of power-up
// - cyclic process data exchange is possible within 500 ms of power-up
// - up to eight client connections, each addressing registers independently
`timescale 1ns/1ns
module modbus_input_register_map
    import modbus_regmap_pkg::*;
#(
    parameter int CONN_CYC = CONN_READY_CYC,
    parameter int EXCH_CYC = EXCH_READY_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [CONN_W-1:0] req_conn,
    input  wire logic [15:0]       req_addr,
    input  wire logic [15:0]       req_wdata,
    output logic                   resp_valid,
    output logic      [CONN_W-1:0] resp_conn,
    output logic      [15:0]       resp_rdata,
    output logic      [7:0]        resp_exc,
    input  wire logic [15:0]       sensor_input_line,
    input  wire logic              supply_under,
    input  wire logic              supply_surge,
    input  wire logic              supply_short,
    input  wire logic              over_temp,
    output logic                   io_warning,
    output logic                   cmd_error,
    output logic                   conn_ready,
    output logic                   exch_ready
);
    logic [SYNC_W-1:0] syn;
    logic              conn_done;
    logic              exch_done;

    pin_sync #(.W(SYNC_W)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({over_temp, supply_short, supply_surge, supply_under, sensor_input_line}),
        .q     (syn)
    );

    ready_timer #(.LIMIT(CONN_CYC)) u_conn_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .done  (conn_done)
    );

    ready_timer #(.LIMIT(EXCH_CYC)) u_exch_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .done  (exch_done)
    );

    // startup sequencing
    boot_state_e state_r;
    boot_state_e state_nxt;
    logic        conn_ready_r;
    logic        conn_ready_nxt;
    logic        exch_ready_r;
    logic        exch_ready_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT: begin
                if (conn_done) begin
                    state_nxt = ST_LISTEN;
                end
            end
            ST_LISTEN: begin
                if (exch_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_BOOT;
            end
        endcase
        conn_ready_nxt = (state_nxt != ST_BOOT);
        exch_ready_nxt = (state_nxt == ST_RUN);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= ST_BOOT;
            conn_ready_r <= 1'b0;
            exch_ready_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            conn_ready_r <= conn_ready_nxt;
            exch_ready_r <= exch_ready_nxt;
        end
    end

    // live register contents
    logic [15:0] diag_r;
    logic [15:0] diag_nxt;
    logic [15:0] stat_r;
    logic [15:0] stat_nxt;
    logic [15:0] input_r;
    logic [15:0] input_nxt;
    logic        warn_r;
    logic        warn_nxt;
    logic        clear_cmd;

    always_comb begin
        diag_nxt                 = REG_RESET;
        diag_nxt[DIAG_UNDER_BIT] = syn[16];
        diag_nxt[DIAG_SURGE_BIT] = syn[17];
        diag_nxt[DIAG_SHORT_BIT] = syn[18];
        diag_nxt[DIAG_TEMP_BIT]  = syn[19];
        // input 1 is bit 0 of the first byte on the wire, i.e. the high byte
        input_nxt = {syn[7:0], syn[15:8]};
        // a fault still present in the clearing cycle re-latches: set beats clear
        warn_nxt = (diag_r != REG_RESET) || (warn_r && !clear_cmd);
        stat_nxt               = REG_RESET;
        stat_nxt[STAT_ERR_BIT] = (diag_r != REG_RESET) || warn_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diag_r  <= REG_RESET;
            stat_r  <= REG_RESET;
            input_r <= REG_RESET;
            warn_r  <= 1'b0;
        end else begin
            diag_r  <= diag_nxt;
            stat_r  <= stat_nxt;
            input_r <= input_nxt;
            warn_r  <= warn_nxt;
        end
    end

    // request decode; every connection is served from the same shared bank
    logic              one_hot;
    logic              resp_valid_r;
    logic              resp_valid_nxt;
    logic [CONN_W-1:0] resp_conn_r;
    logic [CONN_W-1:0] resp_conn_nxt;
    logic [15:0]       resp_rdata_r;
    logic [15:0]       resp_rdata_nxt;
    logic [7:0]        resp_exc_r;
    logic [7:0]        resp_exc_nxt;
    logic              cmd_error_r;
    logic              cmd_error_nxt;

    assign one_hot = (req_wdata != 16'h0000) && ((req_wdata & (req_wdata - 16'h0001)) == 16'h0000);

    always_comb begin
        resp_valid_nxt = req_valid;
        resp_conn_nxt  = req_conn;
        resp_rdata_nxt = REG_RESET;
        resp_exc_nxt   = EXC_NONE;
        cmd_error_nxt  = 1'b0;
        clear_cmd      = 1'b0;
        if (req_valid) begin
            if (!exch_ready_r) begin
                resp_exc_nxt = EXC_BUSY;
            end else begin
                case (req_addr)
                    CMD_ADDR: begin
                        if (!req_write) begin
                            resp_exc_nxt = EXC_ILLEGAL_ADDR;
                        end else if (!one_hot) begin
                            resp_exc_nxt  = EXC_ILLEGAL_VALUE;
                            cmd_error_nxt = 1'b1;
                        end else begin
                            clear_cmd = (req_wdata == CMD_CLEAR_CODE);
                        end
                    end
                    STAT_ADDR, DIAG_ADDR, INPUT_ADDR: begin
                        if (req_write) begin
                            resp_exc_nxt = EXC_ILLEGAL_ADDR;
                        end else if (req_addr == STAT_ADDR) begin
                            // status is byte-wide: high byte forced to zero
                            resp_rdata_nxt = {8'h00, stat_r[7:0]};
                        end else if (req_addr == DIAG_ADDR) begin
                            resp_rdata_nxt = diag_r;
                        end else begin
                            resp_rdata_nxt = input_r;
                        end
                    end
                    default: begin
                        resp_exc_nxt = EXC_ILLEGAL_ADDR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resp_valid_r <= 1'b0;
            resp_conn_r  <= '0;
            resp_rdata_r <= REG_RESET;
            resp_exc_r   <= EXC_NONE;
            cmd_error_r  <= 1'b0;
        end else begin
            resp_valid_r <= resp_valid_nxt;
            resp_conn_r  <= resp_conn_nxt;
            resp_rdata_r <= resp_rdata_nxt;
            resp_exc_r   <= resp_exc_nxt;
            cmd_error_r  <= cmd_error_nxt;
        end
    end

    assign resp_valid = resp_valid_r;
    assign resp_conn  = resp_conn_r;
    assign resp_rdata = resp_rdata_r;
    assign resp_exc   = resp_exc_r;
    assign cmd_error  = cmd_error_r;
    assign io_warning = warn_r;
    assign conn_ready = conn_ready_r;
    assign exch_ready = exch_ready_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic ro_addr;
    assign ro_addr = (req_addr == STAT_ADDR) || (req_addr == DIAG_ADDR) ||
                     (req_addr == INPUT_ADDR);
    logic bad_cmd;
    assign bad_cmd = req_valid && req_write && req_addr == CMD_ADDR && !one_hot && exch_ready_r;

    AST_RO_WRITE_EXC: assert property (
        req_valid && req_write && ro_addr && exch_ready_r
        |=> resp_valid && resp_exc == EXC_ILLEGAL_ADDR && resp_rdata == 16'h0000)
        else $error("read-only write not refused with exception 02");

    AST_CMD_MULTI_ERR: assert property (
        // back-to-back bad commands are legal, so the pulse may repeat only for them
        bad_cmd |=> cmd_error && resp_exc == EXC_ILLEGAL_VALUE ##1 cmd_error == $past(bad_cmd))
        else $error("bad command value not reported as one-cycle error");

    AST_CMD_NO_READ: assert property (
        req_valid && !req_write && req_addr == CMD_ADDR && exch_ready_r
        |=> resp_exc == EXC_ILLEGAL_ADDR && resp_rdata == 16'h0000)
        else $error("command register read was not refused");

    AST_CMD_CLEAR: assert property (
        req_valid && req_write && req_addr == CMD_ADDR && req_wdata == CMD_CLEAR_CODE
        && exch_ready_r && diag_r == 16'h0000 |=> !io_warning)
        else $error("clear command did not clear the warning");

    AST_WARN_HOLD: assert property (
        io_warning && !clear_cmd |=> io_warning)
        else $error("warning dropped without a clear command");

    AST_STATUS_ERR: assert property (
        diag_r != 16'h0000 |=> stat_r[STAT_ERR_BIT] && io_warning)
        else $error("status error bit or warning missing on fault");

    AST_DIAG_UNDER: assert property (
        syn[16] |=> diag_r[DIAG_UNDER_BIT])
        else $error("undervoltage not shown in diagnostic bit 2");

    AST_DIAG_SURGE_SHORT: assert property (
        ##1 diag_r[DIAG_SURGE_BIT] == $past(syn[17]) && diag_r[DIAG_SHORT_BIT] == $past(syn[18]))
        else $error("surge or short fault not mapped to diagnostic bits");

    AST_DIAG_TEMP: assert property (
        !syn[19] [*2] |-> !diag_r[DIAG_TEMP_BIT])
        else $error("overtemperature bit set without cause");

    AST_INPUT_ORDER: assert property (
        req_valid && !req_write && req_addr == INPUT_ADDR && exch_ready_r
        |=> resp_rdata[15:8] == $past(syn[7:0], 2) && resp_rdata[7:0] == $past(syn[15:8], 2))
        else $error("input word byte order wrong");

    AST_STAT_HIGH_ZERO: assert property (
        req_valid && !req_write && req_addr == STAT_ADDR && exch_ready_r
        |=> resp_rdata[15:1] == 15'h0000)
        else $error("status high or reserved bits not zero");

    AST_DIAG_RESERVED: assert property (
        (diag_r & ~DIAG_MASK) == 16'h0000)
        else $error("reserved diagnostic bit set");

    AST_READY_ORDER: assert property (
        (exch_ready |-> conn_ready) and (req_valid && !exch_ready_r |=> resp_exc == EXC_BUSY))
        else $error("startup readiness order broken");

    AST_CONN_ECHO: assert property (
        req_valid |=> resp_valid && resp_conn == $past(req_conn))
        else $error("response not tagged with requesting connection");

    COV_CLEAR: cover property (io_warning && clear_cmd && diag_r == 16'h0000 ##1 !io_warning);
    COV_MULTI: cover property (cmd_error);
    COV_RO_WRITE: cover property (req_valid && req_write && ro_addr && exch_ready_r);
    COV_RUN: cover property ($rose(exch_ready));
endmodule

// ---- testbench/modbus_client_model.sv ----
// client model on the request side of the register bank
// assumes the bank registers its answer on the same edge that takes the request
`timescale 1ns/1ns
module modbus_client_model
    import modbus_regmap_pkg::*;
(
    input  wire logic              clk,
    output logic                   req_valid,
    output logic                   req_write,
    output logic      [CONN_W-1:0] req_conn,
    output logic      [15:0]       req_addr,
    output logic      [15:0]       req_wdata,
    input  wire logic              resp_valid,
    input  wire logic [CONN_W-1:0] resp_conn,
    input  wire logic [15:0]       resp_rdata,
    input  wire logic [7:0]        resp_exc,
    input  wire logic              cmd_error
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_conn  = '0;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end

    // idle lines carry the inverse of the last value, so sampling outside a request shows up
    task automatic access(input logic wr, input logic [CONN_W-1:0] conn,
                          input logic [15:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata, output logic [7:0] exc,
                          output logic err, output logic ok);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_conn  <= conn;
        req_addr  <= addr;
        req_wdata <= wdata; // command words go out exactly as the scenario asks
        @(posedge clk);
        req_valid <= 1'b0;
        req_write <= ~wr;
        req_conn  <= ~conn;
        req_addr  <= ~addr;
        req_wdata <= ~wdata;
        #1;
        rdata = resp_rdata;
        exc   = resp_exc;
        err   = cmd_error;
        ok    = resp_valid === 1'b1 && resp_conn === conn;
    endtask
endmodule

// ---- testbench/tb_modbus_input_register_map.sv ----
// self-checking bench for the modbus register bank, one task per scenario
// assumes the client model beside it and the shared package
`timescale 1ns/1ns
module tb_modbus_input_register_map
    import modbus_regmap_pkg::*;
;
    localparam int CONN_T = 10;
    localparam int EXCH_T = 20;
    logic              clk;
    logic              rst_n;
    logic              req_valid;
    logic              req_write;
    logic [CONN_W-1:0] req_conn;
    logic [15:0]       req_addr;
    logic [15:0]       req_wdata;
    logic              resp_valid;
    logic [CONN_W-1:0] resp_conn;
    logic [15:0]       resp_rdata;
    logic [7:0]        resp_exc;
    logic [15:0]       sensor_input_line;
    logic [3:0]        faults;
    logic              io_warning;
    logic              cmd_error;
    logic              conn_ready;
    logic              exch_ready;
    logic [15:0]       rd;
    logic [7:0]        ex;
    logic              ce;
    logic              ok;
    int                errors;
    int                cmp_count;

    modbus_input_register_map #(.CONN_CYC(CONN_T), .EXCH_CYC(EXCH_T)) dut (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_conn(req_conn), .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_conn(resp_conn), .resp_rdata(resp_rdata),
        .resp_exc(resp_exc), .sensor_input_line(sensor_input_line),
        .supply_under(faults[0]), .supply_surge(faults[1]), .supply_short(faults[2]),
        .over_temp(faults[3]), .io_warning(io_warning), .cmd_error(cmd_error),
        .conn_ready(conn_ready), .exch_ready(exch_ready)
    );

    modbus_client_model u_client (
        .clk(clk), .req_valid(req_valid), .req_write(req_write), .req_conn(req_conn),
        .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
        .resp_conn(resp_conn), .resp_rdata(resp_rdata), .resp_exc(resp_exc),
        .cmd_error(cmd_error)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [CONN_W-1:0] c, input logic [15:0] a,
                       input logic [15:0] d);
        u_client.access(wr, c, a, d, rd, ex, ce, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value response_echo expected 1 seen %b", ok);
            complete_run();
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // fault pins pass two sync flops and a register, so five edges is ample
    task automatic set_faults(input logic [3:0] f);
        @(posedge clk);
        faults <= f;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_startup();
        int n;
        int conn_at;
        int exch_at;
        conn_at = 0;
        exch_at = 0;
        do_reset();
        for (n = 1; n <= 40; n++) begin
            @(posedge clk);
            #1;
            if (conn_ready === 1'b1 && conn_at == 0) conn_at = n;
            if (exch_ready === 1'b1 && exch_at == 0) exch_at = n;
        end
        chk("conn_ready edges", 16'(CONN_T + 1), 16'(conn_at));
        chk("exch_ready edges", 16'(EXCH_T + 1), 16'(exch_at));
        $display("test startup done");
    endtask

    task automatic t_busy();
        int n;
        do_reset();
        acc(1'b0, 3'd1, STAT_ADDR, 16'h0000);
        chk("busy exc", 16'(EXC_BUSY), 16'(ex));
        for (n = 0; n < 50 && exch_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("exch_ready", 16'h0001, {15'h0000, exch_ready});
        if (exch_ready !== 1'b1) complete_run();
        $display("test busy done");
    endtask

    task automatic t_map();
        logic [15:0] ro [3];
        int i;
        ro = '{STAT_ADDR, DIAG_ADDR, INPUT_ADDR};
        @(posedge clk);
        sensor_input_line <= 16'ha55a;
        repeat (4) @(posedge clk);
        for (i = 0; i < 3; i++) begin
            acc(1'b1, 3'd2, ro[i], 16'hffff);
            chk("ro write exc", 16'(EXC_ILLEGAL_ADDR), 16'(ex));
            chk("ro write rdata", 16'h0000, rd);
        end
        acc(1'b0, 3'd3, INPUT_ADDR, 16'h0000);
        chk("input after ro write", 16'h5aa5, rd);
        acc(1'b0, 3'd4, CMD_ADDR, 16'h0000);
        chk("cmd read exc", 16'(EXC_ILLEGAL_ADDR), 16'(ex));
        acc(1'b0, 3'd5, 16'h1f3e, 16'h0000);
        chk("unmapped exc", 16'(EXC_ILLEGAL_ADDR), 16'(ex));
        acc(1'b0, 3'd6, STAT_ADDR, 16'h0000);
        chk("status idle", 16'h0000, rd);
        acc(1'b0, 3'd7, DIAG_ADDR, 16'h0000);
        chk("diag idle", 16'h0000, rd);
        $display("test map done");
    endtask

    task automatic t_inputs();
        int i;
        logic [15:0] p;
        for (i = 0; i < 8; i++) begin
            p = 16'h0001 << (2 * i + i % 2);
            @(posedge clk);
            sensor_input_line <= p;
            repeat (4) @(posedge clk);
            acc(1'b0, 3'(i), INPUT_ADDR, 16'h0000);
            chk("input word", {p[7:0], p[15:8]}, rd);
        end
        $display("test inputs done");
    endtask

    task automatic t_faults();
        int k;
        int pos [4];
        pos = '{DIAG_UNDER_BIT, DIAG_SURGE_BIT, DIAG_SHORT_BIT, DIAG_TEMP_BIT};
        for (k = 0; k < 4; k++) begin
            set_faults(4'(1 << k));
            acc(1'b0, 3'(k), DIAG_ADDR, 16'h0000);
            chk("diag bit", 16'h0001 << pos[k], rd);
            acc(1'b0, 3'(k), STAT_ADDR, 16'h0000);
            chk("status with fault", 16'h0001, rd);
            set_faults(4'h0);
            acc(1'b0, 3'(k), DIAG_ADDR, 16'h0000);
            chk("diag released", 16'h0000, rd);
            acc(1'b1, 3'(k), CMD_ADDR, CMD_CLEAR_CODE);
            chk("clear exc", 16'(EXC_NONE), 16'(ex));
            chk("warning cleared", 16'h0000, {15'h0000, io_warning});
            acc(1'b0, 3'(k), STAT_ADDR, 16'h0000);
            chk("status after clear", 16'h0000, rd);
        end
        $display("test faults done");
    endtask

    task automatic t_command();
        logic [15:0] val [5];
        logic [7:0] code [5];
        int i;
        val = '{16'h0000, 16'h0180, 16'h0001, 16'h8000, 16'h0081};
        code = '{EXC_ILLEGAL_VALUE, EXC_ILLEGAL_VALUE, EXC_NONE, EXC_NONE, EXC_ILLEGAL_VALUE};
        set_faults(4'h1);
        set_faults(4'h0);
        for (i = 0; i < 5; i++) begin
            acc(1'b1, 3'(i), CMD_ADDR, val[i]);
            chk("cmd exc", 16'(code[i]), 16'(ex));
            chk("cmd_error", {15'h0000, code[i] != EXC_NONE}, {15'h0000, ce});
            chk("warning kept", 16'h0001, {15'h0000, io_warning});
        end
        set_faults(4'h1);
        acc(1'b1, 3'd6, CMD_ADDR, CMD_CLEAR_CODE);
        chk("clear with fault exc", 16'(EXC_NONE), 16'(ex));
        chk("warning with live fault", 16'h0001, {15'h0000, io_warning});
        set_faults(4'h0);
        acc(1'b1, 3'd7, CMD_ADDR, CMD_CLEAR_CODE);
        chk("warning cleared", 16'h0000, {15'h0000, io_warning});
        $display("test command done");
    endtask

    initial begin
        rst_n = 1'b0;
        sensor_input_line = 16'h0000;
        faults = 4'h0;
        errors = 0;
        cmp_count = 0;
        t_startup();
        t_busy();
        t_map();
        t_inputs();
        t_faults();
        t_command();
        complete_run();
    end
endmodule
